/* File: bench/pps_prog_model.sv */
// Programmer tool model driving the programming clock, data and high-voltage reset pins
`timescale 1ns/1ns
module pps_prog_model (
	input  wire logic ref_clk,
	input  wire logic pin_level,
	output logic      prog_clock_pin,
	output logic      prog_data,
	output logic      hv_reset_pin
);
	// Pins rest low; the pin clock stands still between frames
	initial begin
		prog_clock_pin = 1'b0;
		prog_data      = 1'b0;
		hv_reset_pin   = 1'b0;
	end

	// Entry: clock and data held low before the high-voltage reset rises
	task automatic enter();
		@(posedge ref_clk);
		prog_clock_pin <= 1'b0;
		prog_data      <= 1'b0;
		repeat (4) @(posedge ref_clk);
		hv_reset_pin <= 1'b1;
	endtask : enter

	// One 320 ns pin period of 8 ref_clk edges; data changes with the rise
	task automatic bit_cycle(input logic d, output logic q);
		@(posedge ref_clk);
		prog_clock_pin <= 1'b1;
		prog_data      <= d;
		repeat (4) @(posedge ref_clk);
		// Device data is taken as the pin clock falls, as a real programmer does
		prog_clock_pin <= 1'b0;
		q = pin_level;
		repeat (3) @(posedge ref_clk);
	endtask : bit_cycle

	// Shift n bits out, least significant first
	task automatic send(input logic [23:0] v, input int n);
		logic q;
		for (int i = 0; i < n; i++)
			bit_cycle(v[i], q);
	endtask : send

	// Read 16 bits; own drive flips every bit so a released line never looks held
	task automatic read16(output logic [15:0] v);
		logic q;
		for (int i = 0; i < 16; i++) begin
			bit_cycle(~prog_data, q);
			v[i] = q;
		end
	endtask : read16
endmodule : pps_prog_model

/* File: bench/pps_prog_port_tb_top.sv */
// Self-checking bench for the response framer, identity words and serial front end
`timescale 1ns/1ns
module pps_prog_port_tb_top
	import pps_pkg::*;
;
	localparam logic [7:0] VER = 8'h37;  // Arbitrary value
	localparam logic [9:0] DIE = 10'h13c; // Arbitrary value
	localparam logic [5:0] DRV = 6'h2d;  // Arbitrary value
	localparam logic [3:0] FAB = 4'h9;   // Arbitrary value
	localparam logic [5:0] MJ  = 6'h0a;  // Arbitrary value
	localparam logic [5:0] MN  = 6'h31;  // Arbitrary value
	logic        ref_clk, srst, cmd_valid, cmd_ready, cmd_start, exe_done;
	logic        resp_valid, resp_ready, id_rd_en, id_rd_valid, prog_clock_pin;
	logic        prog_data_out, prog_data_oe, mdl_data, pin_level, hv_reset_pin;
	logic        direct_serial_mode, cpu_clk_en, cpu_idle, cpu_exec;
	pps_cmd_t    cmd;
	pps_result_t exe_result;
	pps_resp_t   resp;
	logic [23:0] id_rd_addr, cpu_instr;
	logic [15:0] id_rd_data, readout_holding_reg, rb;
	logic [23:0] ins[4];
	logic [23:0] exec_q[$];
	logic [23:0] id_addr[3] = '{24'hff0000, 24'hff0002, 24'h000004};
	logic [15:0] id_exp[3]  = '{{DIE, DRV}, {FAB, MJ, MN}, 16'h0000};
	int          err_total, num_checks, clk_en_cnt;

	// The wire level: the device wins while it drives, otherwise the programmer
	assign pin_level = prog_data_oe ? prog_data_out : mdl_data;

	pps_prog_port #(.EXEC_VERSION(VER), .DIE_CODE(DIE), .DERIV_CODE(DRV), .FAB_CODE(FAB),
		.MAJOR_STEP(MJ), .MINOR_STEP(MN)) u_pps_prog_port (
		.ref_clk, .srst, .cmd_valid, .cmd, .cmd_ready, .cmd_start, .exe_done, .exe_result,
		.resp_valid, .resp, .resp_ready, .id_rd_en, .id_rd_addr, .id_rd_valid, .id_rd_data,
		.prog_clock_pin, .prog_data_in(pin_level), .prog_data_out, .prog_data_oe,
		.hv_reset_pin, .readout_holding_reg, .direct_serial_mode, .cpu_clk_en, .cpu_idle,
		.cpu_exec, .cpu_instr);

	pps_prog_model u_pps_prog_model (.ref_clk, .pin_level, .prog_clock_pin,
		.prog_data(mdl_data), .hv_reset_pin);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Record every executed instruction and every CPU clock enable
	always @(posedge ref_clk) begin
		if (cpu_exec === 1'b1)
			exec_q.push_back(cpu_instr);
		if (cpu_clk_en === 1'b1)
			clk_en_cnt++;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic chk_resp(input pps_resp_t got, input pps_resp_t exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: response %h expected %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	// Expected header worked out from opcode, count, outcome and blank result
	function automatic pps_resp_t exp_resp(input int op, input int n, input int oc, input bit bl);
		pps_resp_t r;
		int        len;
		len = 2;
		r.hdr0.last_cmd = op[3:0];
		if (op == 0 || op == 3 || op > 11) begin
			r.hdr0.op = 4'h3;
			r.hdr0.qe = 8'h02;
		end else if (op >= 10) begin
			r.hdr0.op = 4'h1;
			r.hdr0.qe = (op == 11) ? VER : (bl ? 8'hf0 : 8'h0f);
		end else if (oc == 0) begin
			r.hdr0.op = 4'h1;
			r.hdr0.qe = 8'h00;
			len = (op == 1) ? n + 2 : (op == 2) ? 3 * ((n + 1) / 2) + 2 : 2;
		end else begin
			r.hdr0.op = 4'h2;
			r.hdr0.qe = (oc == 1 && op >= 4 && op <= 6) ? 8'h01 : 8'h02;
		end
		r.length = len[15:0];
		return r;
	endfunction : exp_resp

	// One command through to its response; a busy-time opcode change must be ignored
	task automatic do_cmd(input int op, input int n, input int oc, input bit bl);
		bit known;
		int k;
		known = !(op == 0 || op == 3 || op > 11);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd       <= '{opcode: op[3:0], count: n[15:0]};
		@(posedge ref_clk);
		cmd.opcode <= ~op[3:0];
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		chk_val({22'h0, cmd_ready, cmd_start}, {22'h0, 1'b0, known});
		if (known) begin
			repeat ($urandom % 4) @(posedge ref_clk);
			exe_done   <= 1'b1;
			exe_result <= '{outcome: pps_outcome_t'(oc), blank: bl};
			@(posedge ref_clk);
			exe_done <= 1'b0;
		end
		for (k = 0; k < 20 && resp_valid !== 1'b1; k++)
			@(posedge ref_clk);
		if (k == 20)
			summarize_late();
		repeat ($urandom % 3) @(posedge ref_clk);
		resp_ready <= 1'b1;
		@(posedge ref_clk);
		chk_resp(resp, exp_resp(op, n, oc, bl));
		resp_ready <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_val({23'h0, cmd_ready}, 24'h000001);
	endtask : do_cmd

	// A wait that ran out counts as a mismatch and ends the run
	task automatic summarize_late();
		err_total++;
		$display("Error %0t: wait limit reached", $time);
		summarize();
	endtask : summarize_late

	initial begin
		{err_total, num_checks, clk_en_cnt} = '0;
		{srst, cmd_valid, exe_done, resp_ready, id_rd_en} = 5'h10;
		{cmd, exe_result, id_rd_addr, readout_holding_reg} = '0;
		void'($urandom(32'h8bdf));
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		// Stray completion while idle must not produce a response
		exe_done <= 1'b1;
		@(posedge ref_clk);
		exe_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk_val({22'h0, resp_valid, cmd_ready}, 24'h000001);
		// Every opcode with every outcome, then read counts 0, 21845, 43690, 65535 and four random ones
		for (int op = 0; op < 16; op++)
			for (int oc = 0; oc < 3; oc++)
				do_cmd(op, $urandom % 9, oc, oc[0]);
		for (int i = 0; i < 8; i++)
			do_cmd(1 + i % 2, (i < 4) ? i * 21845 : $urandom % 65536, 0, 0);
		$display("test commands done");
		// Identity words back to back, then an unmapped address
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk);
			if (i > 1)
				chk_val({7'h0, id_rd_valid, id_rd_data}, {8'h01, id_exp[i-2]});
			id_rd_en   <= (i < 3);
			id_rd_addr <= id_addr[i % 3];
		end
		$display("test identity done");
		// Serial mode: forced code, execute, readback, reserved code, execute
		ins[0] = 24'h000000;
		for (int i = 1; i < 4; i++)
			ins[i] = 24'($urandom);
		readout_holding_reg <= 16'($urandom);
		u_pps_prog_model.enter();
		repeat (6) @(posedge ref_clk);
		chk_val({23'h0, direct_serial_mode}, 24'h000001);
		u_pps_prog_model.send(24'h00000f, 4);
		u_pps_prog_model.send(ins[1], 24);
		u_pps_prog_model.send(24'h000000, 4);
		u_pps_prog_model.send(ins[2], 24);
		u_pps_prog_model.send(24'h000001, 4);
		u_pps_prog_model.send(24'h000000, 8);
		u_pps_prog_model.read16(rb);
		chk_val({8'h0, rb}, {8'h0, readout_holding_reg});
		u_pps_prog_model.send(24'h000005, 4);
		repeat (4) @(posedge ref_clk);
		chk_val({22'h0, prog_data_oe, cpu_idle}, 24'h000001);
		u_pps_prog_model.send(24'h000000, 4);
		u_pps_prog_model.send(ins[3], 24);
		repeat (8) @(posedge ref_clk);
		chk_val(24'(exec_q.size()), 24'h000004);
		for (int i = 0; i < 4; i++)
			chk_val(exec_q[i], ins[i]);
		// One enable per pin rise over all 116 bits clocked
		chk_val(24'(clk_en_cnt), 24'h000074);
		$display("test serial done");
		summarize();
	end
endmodule : pps_prog_port_tb_top

/* File: logic/pps_pin_sync.sv */
// Two-flop synchroniser with edge detection for pins entering the ref_clk domain
`timescale 1ns/1ns
module pps_pin_sync #(
	parameter int W = 3
) (
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Only s2 reads s1; edges come from the settled pair s2/s3
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign q    = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule : pps_pin_sync

/* File: logic/pps_pkg.sv */
// Constants, types and carriers of the programming port response framer and serial front end
package pps_pkg;
	// Response opcodes and query or error byte values
	localparam logic [3:0]  RSP_PASS         = 4'h1;
	localparam logic [3:0]  RSP_FAIL         = 4'h2;
	localparam logic [3:0]  RSP_UNKNOWN      = 4'h3;
	localparam logic [7:0]  QE_NO_ERR        = 8'h00;
	localparam logic [7:0]  QE_VERIFY        = 8'h01;
	localparam logic [7:0]  QE_OTHER         = 8'h02;
	localparam logic [7:0]  QE_BLANK         = 8'hf0;
	localparam logic [7:0]  QE_NOT_BLANK     = 8'h0f;
	localparam logic [15:0] HDR_WORDS        = 16'h0002;
	// Command opcodes and the set of opcodes the agent recognises
	localparam logic [3:0]  CMD_DATA_READ    = 4'h1;
	localparam logic [3:0]  CMD_PROG_READ    = 4'h2;
	localparam logic [3:0]  CMD_DATA_WRITE   = 4'h4;
	localparam logic [3:0]  CMD_PROG_WRITE   = 4'h5;
	localparam logic [3:0]  CMD_CONFIG_WRITE = 4'h6;
	localparam logic [3:0]  CMD_BLANK_QUERY  = 4'ha;
	localparam logic [3:0]  CMD_VER_QUERY    = 4'hb;
	localparam logic [15:0] CMD_KNOWN_MASK   = 16'h0ff6;
	// Identity word addresses
	localparam logic [23:0] ADDR_IDENTITY    = 24'hff0000;
	localparam logic [23:0] ADDR_STEPPING    = 24'hff0002;
	// Serial mode control codes and bit counts
	localparam logic [3:0]  CC_EXEC          = 4'h0;
	localparam logic [3:0]  CC_READBACK      = 4'h1;
	localparam logic [4:0]  CODE_BITS        = 5'h04;
	localparam logic [4:0]  INSTR_BITS       = 5'h18;
	localparam logic [4:0]  RB_PREP_CLKS     = 5'h08;
	localparam logic [4:0]  RB_BITS          = 5'h10;
	localparam logic [23:0] INSTR_NOP        = 24'h000000;

	typedef enum logic [1:0] {OUT_OK = 2'h0, OUT_VERIFY = 2'h1, OUT_OTHER = 2'h2} pps_outcome_t;
	typedef struct packed {logic [3:0] opcode; logic [15:0] count;} pps_cmd_t;
	typedef struct packed {pps_outcome_t outcome; logic blank;} pps_result_t;
	// Header word one: response opcode on top, echoed command, then the query or error byte
	typedef struct packed {
		logic [3:0] op;
		logic [3:0] last_cmd;
		logic [7:0] qe;
	} pps_hdr0_t;
	typedef struct packed {pps_hdr0_t hdr0; logic [15:0] length;} pps_resp_t;
	typedef struct packed {logic [9:0] die; logic [5:0] deriv;} pps_ident_t;
	typedef struct packed {logic [3:0] fab; logic [5:0] major; logic [5:0] minor;} pps_step_t;

	typedef enum logic [2:0] {RS_IDLE = 3'h1, RS_BUSY = 3'h2, RS_SEND = 3'h4} pps_rs_t;
	typedef enum logic [5:0] {
		SER_OFF = 6'h01, SER_CODE = 6'h02, SER_INSTR = 6'h04,
		SER_RB_PREP = 6'h08, SER_RB_OUT = 6'h10, SER_RB_HOLD = 6'h20
	} pps_ser_t;

	typedef struct packed {
		pps_rs_t     rs;
		logic        cmd_ready;
		logic        cmd_start;
		logic [3:0]  last_op;
		logic [15:0] count;
		logic        resp_valid;
		pps_resp_t   resp;
		logic        id_valid;
		logic [15:0] id_data;
		pps_ser_t    ser;
		logic [4:0]  cnt;
		logic [23:0] sh;
		logic        forced;
		logic        mode;
		logic        clk_en;
		logic        idle;
		logic        exec;
		logic [23:0] instr;
		logic        dout;
		logic        doe;
	} pps_state_t;
endpackage : pps_pkg

/* File: logic/pps_prog_port.sv */
// Programming agent response sequencer, identity words and serial mode front end
`timescale 1ns/1ns
module pps_prog_port
	import pps_pkg::*;
#(
	parameter logic [7:0] EXEC_VERSION = 8'h10,   // Version.revision of the agent
	parameter logic [9:0] DIE_CODE     = 10'h2a5, // Arbitrary value
	parameter logic [5:0] DERIV_CODE   = 6'h15,   // Arbitrary value
	parameter logic [3:0] FAB_CODE     = 4'h3,    // Arbitrary value
	parameter logic [5:0] MAJOR_STEP   = 6'h01,   // Arbitrary value
	parameter logic [5:0] MINOR_STEP   = 6'h00    // Arbitrary value
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        cmd_valid,
	input  pps_cmd_t         cmd,
	output logic             cmd_ready,
	output logic             cmd_start,
	input  wire logic        exe_done,
	input  pps_result_t      exe_result,
	output logic             resp_valid,
	output pps_resp_t        resp,
	input  wire logic        resp_ready,
	input  wire logic        id_rd_en,
	input  wire logic [23:0] id_rd_addr,
	output logic             id_rd_valid,
	output logic      [15:0] id_rd_data,
	input  wire logic        prog_clock_pin,
	input  wire logic        prog_data_in,
	output logic             prog_data_out,
	output logic             prog_data_oe,
	input  wire logic        hv_reset_pin,
	input  wire logic [15:0] readout_holding_reg,
	output logic             direct_serial_mode,
	output logic             cpu_clk_en,
	output logic             cpu_idle,
	output logic             cpu_exec,
	output logic      [23:0] cpu_instr
);
	pps_state_t  st_r;
	pps_state_t  st_nxt;
	pps_resp_t   fmt_resp;
	pps_ident_t  ident;
	pps_step_t   step;
	logic [2:0]  pin_q;
	logic [2:0]  pin_rise;
	logic [2:0]  pin_fall;
	logic [3:0]  fmt_op;
	logic [15:0] fmt_count;
	logic        fmt_unknown;
	logic        pclk_rise;
	logic        pclk_fall;
	logic        pdat_q;
	logic        hv_q;
	logic [3:0]  code;

	// New serial bit enters at the top so the first (LSB) bit ends lowest
	function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic b);
		return {b, sh[23:1]};
	endfunction : shift_in

	function automatic logic cmd_known(input logic [3:0] op);
		return CMD_KNOWN_MASK[op];
	endfunction : cmd_known

	// Fixed identity contents, never gated by code protection
	assign ident = '{die: DIE_CODE, deriv: DERIV_CODE};
	assign step  = '{fab: FAB_CODE, major: MAJOR_STEP, minor: MINOR_STEP};

	// Pins from the programmer are asynchronous to ref_clk
	pps_pin_sync #(
		.W (3)
	) u_sync (
		.ref_clk (ref_clk),
		.srst    (srst),
		.d       ({hv_reset_pin, prog_data_in, prog_clock_pin}),
		.q       (pin_q),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	assign pclk_rise = pin_rise[0];
	assign pclk_fall = pin_fall[0];
	assign pdat_q    = pin_q[1];
	assign hv_q      = pin_q[2];

	// Formatter sees the live command when idle, the held one while busy
	assign fmt_op      = (st_r.rs == RS_IDLE) ? cmd.opcode : st_r.last_op;
	assign fmt_count   = (st_r.rs == RS_IDLE) ? cmd.count : st_r.count;
	assign fmt_unknown = (st_r.rs == RS_IDLE) && !cmd_known(cmd.opcode);

	pps_resp_fmt u_fmt (
		.op      (fmt_op),
		.count   (fmt_count),
		.unknown (fmt_unknown),
		.result  (exe_result),
		.version (EXEC_VERSION),
		.resp    (fmt_resp)
	);

	// Response sequencer, identity reads and serial front end next state
	always_comb begin
		st_nxt           = st_r;
		st_nxt.cmd_start = 1'b0;
		st_nxt.id_valid  = 1'b0;
		st_nxt.clk_en    = 1'b0;
		st_nxt.exec      = 1'b0;
		code             = CC_EXEC;

		// One command in flight; the ready drop holds off the next one
		unique case (st_r.rs)
			RS_IDLE: begin
				if (cmd_valid) begin
					st_nxt.last_op   = cmd.opcode;
					st_nxt.count     = cmd.count;
					st_nxt.cmd_ready = 1'b0;
					if (cmd_known(cmd.opcode)) begin
						st_nxt.cmd_start = 1'b1;
						st_nxt.rs        = RS_BUSY;
					end else begin
						st_nxt.resp       = fmt_resp;
						st_nxt.resp_valid = 1'b1;
						st_nxt.rs         = RS_SEND;
					end
				end
			end
			RS_BUSY: begin
				if (exe_done) begin
					st_nxt.resp       = fmt_resp;
					st_nxt.resp_valid = 1'b1;
					st_nxt.rs         = RS_SEND;
				end
			end
			RS_SEND: begin
				if (resp_ready) begin
					st_nxt.resp_valid = 1'b0;
					st_nxt.cmd_ready  = 1'b1;
					st_nxt.rs         = RS_IDLE;
				end
			end
		endcase

		// Identity words answer one cycle after the request
		if (id_rd_en) begin
			st_nxt.id_valid = 1'b1;
			if (id_rd_addr == ADDR_IDENTITY) begin
				st_nxt.id_data = ident;
			end else if (id_rd_addr == ADDR_STEPPING) begin
				st_nxt.id_data = step;
			end else begin
				st_nxt.id_data = '0;
			end
		end

		// Serial mode lives only while the high-voltage reset is up
		if (!hv_q) begin
			st_nxt.ser   = SER_OFF;
			st_nxt.mode  = 1'b0;
			st_nxt.doe   = 1'b0;
			st_nxt.dout  = 1'b0;
			st_nxt.idle  = 1'b1;
			st_nxt.cnt   = '0;
		end else begin
			st_nxt.mode   = 1'b1;
			st_nxt.clk_en = pclk_rise;
			unique case (st_r.ser)
				SER_OFF: begin
					st_nxt.ser    = SER_CODE;
					st_nxt.forced = 1'b1;
					st_nxt.idle   = 1'b1;
					st_nxt.cnt    = '0;
				end
				SER_CODE: begin
					if (pclk_fall) begin
						st_nxt.sh  = shift_in(st_r.sh, pdat_q);
						st_nxt.cnt = st_r.cnt + 5'h01;
						if (st_r.cnt == CODE_BITS - 5'h01) begin
							st_nxt.cnt    = '0;
							st_nxt.idle   = 1'b1;
							st_nxt.forced = 1'b0;
							code = st_r.forced ? CC_EXEC : st_nxt.sh[23:20];
							if (st_r.forced) begin
								st_nxt.exec  = 1'b1;
								st_nxt.instr = INSTR_NOP;
							end
							if (code == CC_EXEC) begin
								st_nxt.ser = SER_INSTR;
							end else if (code == CC_READBACK) begin
								st_nxt.ser = SER_RB_PREP;
							end else begin
								st_nxt.ser = SER_CODE;
							end
						end
					end
				end
				SER_INSTR: begin
					// CPU stays stalled while the instruction shifts in
					if (pclk_fall) begin
						st_nxt.sh  = shift_in(st_r.sh, pdat_q);
						st_nxt.cnt = st_r.cnt + 5'h01;
						if (st_r.cnt == INSTR_BITS - 5'h01) begin
							st_nxt.cnt   = '0;
							st_nxt.exec  = 1'b1;
							st_nxt.instr = st_nxt.sh;
							st_nxt.idle  = 1'b0;
							st_nxt.ser   = SER_CODE;
						end
					end
				end
				SER_RB_PREP: begin
					if (pclk_fall) begin
						st_nxt.cnt = st_r.cnt + 5'h01;
						if (st_r.cnt == RB_PREP_CLKS - 5'h01) begin
							st_nxt.cnt = '0;
							st_nxt.sh  = {8'h00, readout_holding_reg};
							st_nxt.ser = SER_RB_OUT;
						end
					end
				end
				SER_RB_OUT: begin
					// Drive on rise, LSB first; the programmer samples on fall
					if (pclk_rise) begin
						st_nxt.doe  = 1'b1;
						st_nxt.dout = st_r.sh[0];
						st_nxt.sh   = st_r.sh >> 1;
						st_nxt.cnt  = st_r.cnt + 5'h01;
					end else if (pclk_fall && st_r.cnt == RB_BITS) begin
						st_nxt.cnt = '0;
						st_nxt.ser = SER_RB_HOLD;
					end
				end
				SER_RB_HOLD: begin
					// Last bit stays on the pin until the following rise
					if (pclk_rise) begin
						st_nxt.doe = 1'b0;
						st_nxt.ser = SER_CODE;
					end
				end
				default: begin
					st_nxt.ser = SER_OFF;
				end
			endcase
		end
	end

	// Single state register for the whole block
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r           <= '0;
			st_r.rs        <= RS_IDLE;
			st_r.ser       <= SER_OFF;
			st_r.cmd_ready <= 1'b1;
			st_r.idle      <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_ready          = st_r.cmd_ready;
	assign cmd_start          = st_r.cmd_start;
	assign resp_valid         = st_r.resp_valid;
	assign resp               = st_r.resp;
	assign id_rd_valid        = st_r.id_valid;
	assign id_rd_data         = st_r.id_data;
	assign prog_data_out      = st_r.dout;
	assign prog_data_oe       = st_r.doe;
	assign direct_serial_mode = st_r.mode;
	assign cpu_clk_en         = st_r.clk_en;
	assign cpu_idle           = st_r.idle;
	assign cpu_exec           = st_r.exec;
	assign cpu_instr          = st_r.instr;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// Checks on the response framing
	a_unknown_answer: assert property (
		cmd_valid && cmd_ready && !cmd_known(cmd.opcode)
		|=> resp_valid && resp.hdr0.op == RSP_UNKNOWN && resp.hdr0.last_cmd == $past(cmd.opcode))
		else $error("unknown command not answered with unknown opcode");

	a_known_starts: assert property (
		cmd_valid && cmd_ready && cmd_known(cmd.opcode) |=> cmd_start && !resp_valid)
		else $error("known command did not start the agent");

	a_done_answers: assert property (
		st_r.rs == RS_BUSY && exe_done |=> resp_valid && resp.hdr0.last_cmd == st_r.last_op)
		else $error("completion did not produce a response");

	a_query_pass: assert property (
		$rose(resp_valid) && resp.hdr0.last_cmd == CMD_BLANK_QUERY
		|-> resp.hdr0.op == RSP_PASS && (resp.hdr0.qe == QE_BLANK || resp.hdr0.qe == QE_NOT_BLANK))
		else $error("blank query answer malformed");

	a_fail_code: assert property (
		$rose(resp_valid) && resp.hdr0.op == RSP_FAIL
		|-> resp.hdr0.qe == QE_VERIFY || resp.hdr0.qe == QE_OTHER)
		else $error("failure response carries a bad error byte");

	a_plain_length: assert property (
		resp_valid && (resp.hdr0.last_cmd != CMD_DATA_READ && resp.hdr0.last_cmd != CMD_PROG_READ
		|| resp.hdr0.op != RSP_PASS) |-> resp.length == HDR_WORDS)
		else $error("plain response length is not two");

	a_single_cmd: assert property (
		resp_valid |-> !cmd_ready ##1 (!cmd_start))
		else $error("second command accepted while a response is pending");

	// Checks on the serial front end
	a_exec_after_shift: assert property (
		cpu_exec && !$past(st_r.forced) |-> $past(st_r.ser) == SER_INSTR && st_r.ser == SER_CODE)
		else $error("instruction executed outside the shift sequence");

	a_forced_nop: assert property (
		$past(st_r.forced) && !st_r.forced && st_r.mode |-> cpu_exec && cpu_instr == INSTR_NOP
		&& st_r.ser == SER_INSTR)
		else $error("first code after entry not forced to execute a no-op");

	a_oe_hold: assert property (
		$fell(prog_data_oe) && hv_q |-> $past(pclk_rise) && $past(st_r.ser) == SER_RB_HOLD)
		else $error("data pin released at the wrong moment");

	a_clk_follow: assert property (
		pclk_rise && hv_q && st_r.mode |=> cpu_clk_en)
		else $error("cpu clock enable missed a programming clock rise");

	// Checks on the handshake, identity reads, reserved codes and readback drive
	a_ready_drop: assert property (
		cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("command taken without dropping ready");

	a_id_answer: assert property (
		id_rd_en && id_rd_addr == ADDR_IDENTITY
		|=> id_rd_valid && id_rd_data == {DIE_CODE, DERIV_CODE})
		else $error("identity word read answered wrongly");

	// The code variable only leaves the execute value at a completed code
	a_reserved_idle: assert property (
		code != CC_EXEC && code != CC_READBACK
		|=> st_r.ser == SER_CODE && cpu_idle && !cpu_exec && !prog_data_oe)
		else $error("reserved control code changed the CPU state");

	a_rb_drive: assert property (
		st_r.ser == SER_RB_OUT && pclk_rise && hv_q
		|=> prog_data_oe && prog_data_out == $past(st_r.sh[0]))
		else $error("readback bit not driven on the clock rise");
endmodule : pps_prog_port

/* File: logic/pps_resp_fmt.sv */
// Builds the two response header words from command, outcome and query data
`timescale 1ns/1ns
module pps_resp_fmt
	import pps_pkg::*;
(
	input  wire logic [3:0]  op,
	input  wire logic [15:0] count,
	input  wire logic        unknown,
	input  pps_result_t      result,
	input  wire logic [7:0]  version,
	output pps_resp_t        resp
);
	// Program reads pack two 24-bit words into three 16-bit words
	function automatic logic [15:0] prog_len(input logic [15:0] n);
		logic [17:0] halves;
		halves = ({2'b00, n} + 18'h00001) >> 1;
		return 16'((halves * 18'h00003) + 18'h00002);
	endfunction : prog_len

	always_comb begin
		resp.hdr0.last_cmd = op;
		resp.length        = HDR_WORDS;
		if (unknown) begin
			resp.hdr0.op = RSP_UNKNOWN;
			resp.hdr0.qe = QE_OTHER;
		end else if (op == CMD_BLANK_QUERY) begin
			resp.hdr0.op = RSP_PASS;
			resp.hdr0.qe = result.blank ? QE_BLANK : QE_NOT_BLANK;
		end else if (op == CMD_VER_QUERY) begin
			resp.hdr0.op = RSP_PASS;
			resp.hdr0.qe = version;
		end else if (result.outcome == OUT_OK) begin
			resp.hdr0.op = RSP_PASS;
			resp.hdr0.qe = QE_NO_ERR;
			if (op == CMD_DATA_READ) begin
				resp.length = count + HDR_WORDS;
			end else if (op == CMD_PROG_READ) begin
				resp.length = prog_len(count);
			end
		end else begin
			resp.hdr0.op = RSP_FAIL;
			// Verify failure only applies to the three write commands
			if (result.outcome == OUT_VERIFY && (op == CMD_DATA_WRITE ||
				op == CMD_PROG_WRITE || op == CMD_CONFIG_WRITE)) begin
				resp.hdr0.qe = QE_VERIFY;
			end else begin
				resp.hdr0.qe = QE_OTHER;
			end
		end
	end
endmodule : pps_resp_fmt
